// >>> design/tcv_top.sv
// Two timer channels: value registers with byte interlocks, compare output and full-duty force.
module tcv_top
   import tcv_pkg::*;
#(
   parameter int NUM_CH = 2
)
(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] avsAddress,
   input  wire logic              avsRead,
   input  wire logic              avsWrite,
   input  wire logic [31:0]       avsWritedata,
   input  wire logic [3:0]        avsByteenable,
   output logic [31:0]            avsReaddata,
   output logic                   avsWaitrequest,
   input  wire logic [15:0]       counterValue,
   input  wire logic              counterOverflow,
   input  wire logic [NUM_CH-1:0] capturePin,
   output logic [NUM_CH-1:0]      channelOut,
   output logic                   irq
);

   // ***************************************************************
   // State of the block.
   // ***************************************************************
   typedef struct packed
   {
      logic [NUM_CH-1:0][15:0]      value;
      logic [NUM_CH-1:0][CTL_W-1:0] ctrl;
      logic [NUM_CH-1:0]            capBlock;
      logic [NUM_CH-1:0]            cmpBlock;
      logic [NUM_CH-1:0]            forceAct;
      logic [NUM_CH-1:0]            pwmLevel;
      logic [NUM_CH-1:0]            outLevel;
      logic [NUM_CH-1:0]            sync1;
      logic [NUM_CH-1:0]            sync2;
      logic [NUM_CH-1:0]            syncPrev;
      logic [NUM_CH-1:0]            status;
      logic [NUM_CH-1:0]            mask;
      logic                         irq;
      logic                         waitReq;
      logic [31:0]                  rdata;
   } tcv_state_s;

   localparam tcv_state_s STATE_RST = '{
      value    : {NUM_CH{VALUE_RST}},
      ctrl     : {NUM_CH{CTRL_RST}},
      capBlock : '0,
      cmpBlock : '0,
      forceAct : '0,
      pwmLevel : '0,
      outLevel : '0,
      sync1    : '0,
      sync2    : '0,
      syncPrev : '0,
      status   : '0,
      mask     : '0,
      irq      : 1'b0,
      waitReq  : 1'b1,
      rdata    : RDATA_RST
   };

   localparam logic [1:0][6:0] IDX_HIGH = {IDX_CH1_HIGH, IDX_CH0_HIGH};
   localparam logic [1:0][6:0] IDX_LOW  = {IDX_CH1_LOW, IDX_CH0_LOW};
   localparam logic [1:0][6:0] IDX_CTRL = {IDX_CTRL1, IDX_CTRL0};

   tcv_state_s s_q;
   tcv_state_s s_d;

   // ***************************************************************
   // Next-state logic.
   // ***************************************************************
   always_comb
   begin
      logic [IDX_W-1:0]  idx;
      logic              request;
      logic              doWrite;
      logic              doRead;
      logic [NUM_CH-1:0] setFlag;
      logic [NUM_CH-1:0] clrFlag;
      logic [1:0]        edgeSel;
      logic              captureMode;
      logic              compareMode;
      logic              rise;
      logic              fall;
      logic              edgeHit;
      logic              match;
      idx         = avsAddress[ADDR_W-1:2];
      request     = avsRead | avsWrite;
      doWrite     = avsWrite & ~s_q.waitReq & avsByteenable[0];
      doRead      = avsRead & ~s_q.waitReq;
      setFlag     = '0;
      clrFlag     = '0;
      edgeSel     = EDGE_NONE;
      captureMode = 1'b0;
      compareMode = 1'b0;
      rise        = 1'b0;
      fall        = 1'b0;
      edgeHit     = 1'b0;
      match       = 1'b0;
      s_d         = s_q;

      // Pin synchronisers.
      s_d.sync1    = capturePin;
      s_d.sync2    = s_q.sync1;
      s_d.syncPrev = s_q.sync2;

      // Bus handshake: one wait cycle, then completion.
      if (request && s_q.waitReq)
      begin
         s_d.waitReq = 1'b0;
         s_d.rdata   = RDATA_RST;
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (idx == IDX_HIGH[c])
            begin
               s_d.rdata[7:0] = s_q.value[c][15:8];
            end
            else if (idx == IDX_LOW[c])
            begin
               s_d.rdata[7:0] = s_q.value[c][7:0];
            end
            else if (idx == IDX_CTRL[c])
            begin
               s_d.rdata[CTL_W-1:0] = s_q.ctrl[c];
            end
         end
         if (idx == IDX_STATUS)
         begin
            s_d.rdata[NUM_CH-1:0] = s_q.status;
         end
         else if (idx == IDX_MASK)
         begin
            s_d.rdata[NUM_CH-1:0] = s_q.mask;
         end
      end
      else
      begin
         s_d.waitReq = 1'b1;
      end

      if (doWrite && idx == IDX_STATUS)
      begin
         clrFlag = avsWritedata[NUM_CH-1:0];
      end
      if (doWrite && idx == IDX_MASK)
      begin
         s_d.mask = avsWritedata[NUM_CH-1:0];
      end

      // Per-channel behaviour.
      for (int c = 0; c < NUM_CH; c++)
      begin
         edgeSel     = s_q.ctrl[c][CTL_EDGE_LO +: 2];
         compareMode = s_q.ctrl[c][CTL_BUF_BIT] | s_q.ctrl[c][CTL_UNBUF_BIT];
         captureMode = ~compareMode & (edgeSel != EDGE_NONE);
         rise        = s_q.sync2[c] & ~s_q.syncPrev[c];
         fall        = ~s_q.sync2[c] & s_q.syncPrev[c];
         edgeHit     = (rise & edgeSel[0]) | (fall & edgeSel[1]);

         if (doWrite && idx == IDX_CTRL[c])
         begin
            s_d.ctrl[c] = avsWritedata[CTL_W-1:0];
         end

         // Value register holds either capture or compare value.
         if (doWrite && idx == IDX_HIGH[c])
         begin
            s_d.value[c][15:8] = avsWritedata[7:0];
            if (compareMode)
            begin
               s_d.cmpBlock[c] = 1'b1;
            end
         end
         if (doWrite && idx == IDX_LOW[c])
         begin
            s_d.value[c][7:0] = avsWritedata[7:0];
            s_d.cmpBlock[c]   = 1'b0;
         end
         if (doRead && idx == IDX_HIGH[c] && captureMode)
         begin
            s_d.capBlock[c] = 1'b1;
         end
         if (doRead && idx == IDX_LOW[c])
         begin
            s_d.capBlock[c] = 1'b0;
         end
         if (!captureMode)
         begin
            s_d.capBlock[c] = 1'b0;
         end
         if (!compareMode)
         begin
            s_d.cmpBlock[c] = 1'b0;
         end

         // Capture of the whole counter in one cycle.
         if (captureMode && edgeHit && !s_q.capBlock[c])
         begin
            s_d.value[c] = counterValue;
            setFlag[c]   = 1'b1;
         end

         // Compare match, suppressed while the high byte waits for its low byte.
         match = compareMode & ~s_q.cmpBlock[c] & (counterValue == s_q.value[c]);
         if (match)
         begin
            setFlag[c] = 1'b1;
         end

         // Overflow takes precedence over a simultaneous compare.
         if (compareMode && counterOverflow && s_q.ctrl[c][CTL_OVT_BIT])
         begin
            s_d.pwmLevel[c] = ~s_q.pwmLevel[c];
         end
         else if (match)
         begin
            case (edgeSel)
               ACT_TOGGLE : s_d.pwmLevel[c] = ~s_q.pwmLevel[c];
               ACT_CLEAR  : s_d.pwmLevel[c] = 1'b0;
               EDGE_NONE  : s_d.pwmLevel[c] = s_q.pwmLevel[c];
               default    : s_d.pwmLevel[c] = 1'b1;
            endcase
         end

         // Full-duty force is sampled only at the period boundary.
         if (counterOverflow)
         begin
            s_d.forceAct[c] = s_q.ctrl[c][CTL_FORCE_BIT] & ~s_q.ctrl[c][CTL_OVT_BIT];
         end
         s_d.outLevel[c] = (compareMode & s_d.forceAct[c]) | s_d.pwmLevel[c];
      end

      // Sticky flags, set wins over clear, then interrupt.
      s_d.status = (s_q.status & ~clrFlag) | setFlag;
      s_d.irq    = |(s_d.status & s_d.mask);
   end

   // ***************************************************************
   // State register.
   // ***************************************************************
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= STATE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs.
   // ***************************************************************
   assign avsReaddata    = s_q.rdata;
   assign avsWaitrequest = s_q.waitReq;
   assign channelOut     = s_q.outLevel;
   assign irq            = s_q.irq;

endmodule

// >>> pkg/tcv_pkg.sv
// Constants shared by the two-channel timer value and full-duty block.
//
// How it works
// - With overflow toggle clear, the force bit drives the PWM output at full duty.
// - A force bit change takes effect only from the next PWM period.
// - Full duty holds through the period of clearing, normal duty returns afterwards.
// - Value register holds capture value or compare value; reset content is zero.
// - In capture mode, reading the high byte blocks captures until low byte read.
// - In compare mode, writing the high byte blocks matches and flag until low written.
// - With overflow toggle set on a compare channel, the pin toggles on overflow.
package tcv_pkg;

   // ***************************************************************
   // Register map: index of each register, byte address is four times it.
   // ***************************************************************
   localparam int          ADDR_W          = 9;
   localparam int          IDX_W           = 7;
   localparam logic [6:0]  IDX_CH0_HIGH    = 7'h46;
   localparam logic [6:0]  IDX_CH0_LOW     = 7'h47;
   localparam logic [6:0]  IDX_CH1_HIGH    = 7'h49;
   localparam logic [6:0]  IDX_CH1_LOW     = 7'h4A;
   localparam logic [6:0]  IDX_CTRL0       = 7'h50;
   localparam logic [6:0]  IDX_CTRL1       = 7'h51;
   localparam logic [6:0]  IDX_STATUS      = 7'h52;
   localparam logic [6:0]  IDX_MASK        = 7'h53;

   // ***************************************************************
   // Control register fields.
   // ***************************************************************
   localparam int          CTL_W           = 6;
   localparam int          CTL_FORCE_BIT   = 0;
   localparam int          CTL_OVT_BIT     = 1;
   localparam int          CTL_EDGE_LO     = 2;
   localparam int          CTL_UNBUF_BIT   = 4;
   localparam int          CTL_BUF_BIT     = 5;

   // ***************************************************************
   // Edge and output action codes, reset values.
   // ***************************************************************
   localparam logic [1:0]  EDGE_NONE       = 2'h0;
   localparam logic [1:0]  EDGE_RISE       = 2'h1;
   localparam logic [1:0]  EDGE_FALL       = 2'h2;
   localparam logic [1:0]  ACT_TOGGLE      = 2'h1;
   localparam logic [1:0]  ACT_CLEAR       = 2'h2;
   localparam logic [5:0]  CTRL_RST        = 6'h00;
   localparam logic [15:0] VALUE_RST       = 16'h0000;
   localparam logic [1:0]  FLAG_RST        = 2'h0;
   localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

endpackage

// >>> test/tcv_counter_model.sv
// Free-running counter with overflow pulse, standing in for the timer counter.
module tcv_counter_model #(parameter int PER = 16)
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic        ld,
   input  wire logic [15:0] ldVal,
   output logic [15:0]      counterValue,
   output logic             counterOverflow
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         {counterValue, counterOverflow} <= 17'h00000;
      else
      begin
         counterOverflow <= run && !ld && counterValue == PER - 1;
         if (ld)
            counterValue <= ldVal;
         else if (run)
            counterValue <= (counterValue == PER - 1) ? 16'h0000 : counterValue + 16'h0001;
      end
endmodule

// >>> test/tcv_monitor.sv
// Port checker of the timer value and full-duty block.
module tcv_monitor
   import tcv_pkg::*;
#(parameter int NUM_CH = 2)
(
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] avsAddress,
   input wire logic              avsRead,
   input wire logic              avsWrite,
   input wire logic [31:0]       avsWritedata,
   input wire logic [3:0]        avsByteenable,
   input wire logic [31:0]       avsReaddata,
   input wire logic              avsWaitrequest,
   input wire logic [15:0]       counterValue,
   input wire logic              counterOverflow,
   input wire logic [NUM_CH-1:0] capturePin,
   input wire logic [NUM_CH-1:0] channelOut,
   input wire logic              irq
);
   logic [5:0] ctl_q;
   wire        cmp = ctl_q[5] | ctl_q[4];
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n)
         ctl_q <= 6'h00;
      else if (avsWrite && !avsWaitrequest && avsByteenable[0] && avsAddress[8:2] == IDX_CTRL0)
         ctl_q <= avsWritedata[5:0];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest) else $error("wait low twice");
   a_wait_cause: assert property (!avsWaitrequest |-> $past(avsRead || avsWrite)) else $error("no request");
   a_wait_bound: assert property ((avsRead || avsWrite) && avsWaitrequest |-> ##[1:2] !avsWaitrequest)
      else $error("no answer");
   a_idle_high: assert property (!avsRead && !avsWrite && avsWaitrequest |=> avsWaitrequest)
      else $error("idle answer");
   a_rdata_upper: assert property (!avsWaitrequest |-> avsReaddata[31:8] == 24'h000000)
      else $error("upper data");
   a_force_full: assert property (counterOverflow && cmp && ctl_q[0] && !ctl_q[1] |=> channelOut[0] [*8])
      else $error("no full duty");
   a_force_late: assert property ($rose(channelOut[0]) && ctl_q[0] |-> $past(counterOverflow))
      else $error("force early");
   a_ovf_toggle: assert property (counterOverflow && cmp && ctl_q[1] |=> channelOut[0] != $past(channelOut[0]))
      else $error("no toggle");
endmodule
bind tcv_top tcv_monitor #(.NUM_CH(NUM_CH)) mon (.*);

// >>> test/timer_channel_value_and_full_duty_tb.sv
// Testbench of the timer value and full-duty block.
module timer_channel_value_and_full_duty_tb;
   import tcv_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, rst_n = 0, avsRead = 0, avsWrite = 0, run = 0, ld = 0, o;
   logic [8:0] avsAddress = 0;
   logic [31:0] avsWritedata = 0, seed = 32'd98514;
   logic [3:0] avsByteenable = 4'hF;
   logic [15:0] ldVal = 0, v;
   logic [1:0] capturePin = 0, channelOut;
   logic [31:0] avsReaddata;
   logic avsWaitrequest, counterOverflow, irq;
   logic [15:0] counterValue;
   logic [7:0] r, h;
   logic [6:0] ix;
   int fail_count = 0, comparisons = 0, cyc = 0;
   always #25 clk_sys = ~clk_sys;
   tcv_top #(.NUM_CH(2)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .counterValue(counterValue),
      .counterOverflow(counterOverflow), .capturePin(capturePin), .channelOut(channelOut), .irq(irq));
   tcv_counter_model #(.PER(16)) cnt (.clk_sys(clk_sys), .rst_n(rst_n), .run(run), .ld(ld), .ldVal(ldVal),
      .counterValue(counterValue), .counterOverflow(counterOverflow));
   function logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      comparisons++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task acc(input logic w, input logic [6:0] i, input logic [7:0] d);
      @(posedge clk_sys);
      avsAddress <= {i, 2'h0};
      avsWrite <= w;
      avsRead <= !w;
      avsWritedata <= {24'h000000, d};
      do @(posedge clk_sys); while (avsWaitrequest !== 1'b0);
      r = avsReaddata[7:0];
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   task ldc(input logic [15:0] x);
      @(posedge clk_sys);
      ld <= 1'b1;
      ldVal <= x;
      @(posedge clk_sys);
      ld <= 1'b0;
   endtask
   task pin;
      @(posedge clk_sys);
      capturePin[0] <= ~capturePin[0];
      repeat (8) @(posedge clk_sys);
   endtask
   task ovf;
      do @(negedge clk_sys); while (counterOverflow !== 1'b1);
      @(negedge clk_sys);
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         fail_count++;
         close_out;
      end
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      acc(1, IDX_CTRL0, 8'h10);
      acc(1, IDX_CTRL1, 8'h10);
      for (int k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         ix = k[0] ? IDX_CH1_HIGH : IDX_CH0_HIGH;
         acc(1, ix, seed[15:8]);
         acc(1, ix + 7'h01, seed[7:0]);
         acc(0, ix, 8'h00);
         h = r;
         acc(0, ix + 7'h01, 8'h00);
         chk("value", seed[15:0], {h, r});
      end
      avsByteenable <= 4'h0;
      acc(1, IDX_CH1_LOW, ~seed[7:0]);
      avsByteenable <= 4'hF;
      acc(0, IDX_CH1_LOW, 8'h00);
      chk("byte enable", {8'h00, seed[7:0]}, {8'h00, r});
      acc(1, 7'h48, 8'hA5);
      acc(0, 7'h48, 8'h00);
      chk("unmapped", 16'h0000, {8'h00, r});
      $display("register test done");
      acc(1, IDX_CTRL0, 8'h0C);
      acc(1, IDX_STATUS, 8'h03);
      acc(1, IDX_MASK, 8'h01);
      seed = xs(seed);
      v = seed[15:0];
      ldc(v);
      pin;
      chk("irq set", 16'h0001, {15'h0000, irq});
      acc(0, IDX_CH0_HIGH, 8'h00);
      h = r;
      ldc(~v);
      pin;
      acc(0, IDX_CH0_LOW, 8'h00);
      chk("blocked", v, {h, r});
      pin;
      acc(0, IDX_CH0_HIGH, 8'h00);
      h = r;
      acc(0, IDX_CH0_LOW, 8'h00);
      chk("capture", ~v, {h, r});
      acc(1, IDX_MASK, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      acc(1, IDX_STATUS, 8'h01);
      acc(1, IDX_MASK, 8'h01);
      repeat (2) @(negedge clk_sys);
      chk("irq clear", 16'h0000, {15'h0000, irq});
      $display("capture test done");
      acc(1, IDX_CTRL0, 8'h14);
      acc(1, IDX_CH0_HIGH, 8'h00);
      acc(1, IDX_STATUS, 8'h01);
      o = channelOut[0];
      run <= 1'b1;
      repeat (40) @(posedge clk_sys);
      acc(0, IDX_STATUS, 8'h00);
      chk("status blocked", 16'h0000, {8'h00, r});
      chk("out blocked", {15'h0000, o}, {15'h0000, channelOut[0]});
      acc(1, IDX_CH0_LOW, 8'h05);
      ldc(16'h0004);
      repeat (8) @(posedge clk_sys);
      acc(0, IDX_STATUS, 8'h00);
      chk("status match", 16'h0001, {8'h00, r});
      chk("out match", {15'h0000, ~o}, {15'h0000, channelOut[0]});
      $display("compare test done");
      acc(1, IDX_CTRL0, 8'h18);
      ldc(16'h0004);
      repeat (8) @(posedge clk_sys);
      acc(1, IDX_CH0_HIGH, 8'hFF);
      acc(1, IDX_CH0_LOW, 8'hFF);
      ldc(16'h0001);
      acc(1, IDX_CTRL0, 8'h11);
      chk("force late", 16'h0000, {15'h0000, channelOut[0]});
      for (int k = 0; k < 2; k++)
      begin
         ovf;
         chk("force full", 16'h0001, {15'h0000, channelOut[0]});
      end
      ldc(16'h0001);
      acc(1, IDX_CTRL0, 8'h10);
      chk("force hold", 16'h0001, {15'h0000, channelOut[0]});
      ovf;
      chk("force off", 16'h0000, {15'h0000, channelOut[0]});
      acc(1, IDX_CTRL0, 8'h13);
      ovf;
      o = channelOut[0];
      ovf;
      chk("overflow toggle", {15'h0000, ~o}, {15'h0000, channelOut[0]});
      $display("full duty test done");
      close_out;
   end
endmodule
